// file: verilog/mgmt_pkg.sv
/*
 * Shared constants for the management serial master control block:
 * register offsets, field positions, reset values and frame lengths.
 * Assumes a 32-bit AHB-Lite register port clocked by hclk.
 */
`default_nettype none
package mgmt_pkg;
   // Register byte offsets
   localparam logic [7:0] version_off = 8'h00;
   localparam logic [7:0] control_off = 8'h04;
   localparam logic [7:0] ack_off = 8'h08;
   localparam logic [7:0] cmd_off = 8'h0c;      // Frame request register
   localparam logic [7:0] rdata_off = 8'h10;    // Last read data
   localparam logic [7:0] irq_stat_off = 8'h14; // Sticky event status
   localparam logic [7:0] irq_mask_off = 8'h18; // Event mask
   // Control field positions
   localparam int idle_bit = 31;
   localparam int enable_bit = 30;
   localparam int chan_lsb = 24;
   localparam int pre_dis_bit = 20;
   localparam int fault_bit = 19;
   localparam int fault_en_bit = 18;
   // Command field positions
   localparam int go_bit = 31;
   localparam int write_bit = 30;
   localparam int reg_lsb = 21;
   localparam int phy_lsb = 16;
   // Read-only values
   localparam logic [4:0] highest_channel = 5'h01;
   localparam logic [15:0] module_type_code = 16'h0a5c; // Arbitrary value
   localparam logic [7:0] major_revision = 8'h01;       // Arbitrary value
   localparam logic [7:0] minor_revision = 8'h00;       // Arbitrary value
   // Reset values
   localparam logic [15:0] div_reset = 16'h00ff;
   localparam logic [31:0] ack_reset = 32'h0000_0000;
   // Frame lengths in management clock bits
   localparam logic [5:0] preamble_bits = 6'h20;
   localparam logic [5:0] body_bits = 6'h20;
   // Interrupt status bits
   localparam int ev_done = 0;
   localparam int ev_fault = 1;
   localparam int ev_noack = 2;
endpackage : mgmt_pkg
`default_nettype wire

// file: verilog/mgmt_clk_div.sv
/*
 * Management clock divider: one rise and one fall tick per divider+1 cycles.
 * Assumes the divider value is stable or changes only between frames.
 */
`default_nettype none
module mgmt_clk_div (
   input wire logic hclk,          // System clock
   input wire logic hresetn,       // Async reset, active low
   input wire logic [15:0] divider, // Division value
   output logic tick_rise,         // Management clock rising edge pulse
   output logic tick_fall          // Management clock falling edge pulse
);
   logic [15:0] cnt_reg;
   logic [15:0] cnt_next;

   // Count 0..divider: rise at the end, fall half way, so one period is
   // divider+1 cycles; an odd period gets one extra high cycle
   always_comb begin
      cnt_next = cnt_reg;
      tick_rise = 1'b0;
      tick_fall = 1'b0;
      if (divider == 16'h0000) begin
         cnt_next = 16'h0000;
      end else begin
         // A divider lowered below the count just wraps, no tick
         cnt_next = (cnt_reg >= divider) ? 16'h0000 : cnt_reg + 16'h0001;
         tick_rise = (cnt_reg == divider);
         tick_fall = (cnt_reg == {1'b0, divider[15:1]});
      end
   end

   // Register stage
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_reg <= 16'h0000;
      end else begin
         cnt_reg <= cnt_next;
      end
   end
endmodule : mgmt_clk_div
`default_nettype wire

// file: verilog/mgmt_ctrl.sv
/*
 * Management serial master: control, version and acknowledge registers,
 * clause-22 frame engine, pin fault detection and interrupt.
 * Assumes a single AHB-Lite master and PHYs on an open-drain data line.
 */
// Implementation choices: the register offsets and the AHB-Lite slave port.
// Functional notes
// - Idle bit reads one when engine idle
// - Enable bit gates starting new frames
// - Disable mid-frame finishes then goes idle
// - Highest channel field reads fixed one
// - Preamble disable bit omits preamble
// - Enabled pin readback mismatch sets fault, resets
// - Fault flag cleared by writing one
// - Clock is hclk over divider plus one
// - Zero divider stops management clock
// - Version word holds type, major, minor
// - Reset: disabled, idle, preamble, no fault
// - Acknowledge word resets zero, write-one clears
// - Ack bit follows latest access acknowledge
`default_nettype none
module mgmt_ctrl (
   input wire logic hclk,            // System clock, 100 MHz
   input wire logic hresetn,         // Async reset, active low
   input wire logic hsel,            // Slave select
   input wire logic [31:0] haddr,    // Address
   input wire logic [1:0] htrans,    // Transfer type
   input wire logic hwrite,          // Write flag
   input wire logic [2:0] hsize,     // Transfer size
   input wire logic [31:0] hwdata,   // Write data
   input wire logic hready,          // Bus ready in
   output logic [31:0] hrdata,       // Read data
   output logic hreadyout,           // Slave ready
   output logic hresp,               // Always OKAY
   output logic mgmt_clock,          // Management clock pin
   output logic mgmt_data_o,         // Data pin drive level
   output logic mgmt_data_oe,        // Data pin enable, high drives
   input wire logic mgmt_data_i,     // Data pin readback
   input wire logic mgmt_clock_i,    // Clock pin readback
   output logic irq                  // Level interrupt
);
   typedef enum logic [2:0] {
      st_idle = 3'b000,
      st_pre = 3'b001,
      st_body = 3'b011,
      st_done = 3'b010
   } state_t;

   // Register state
   logic enable_reg, enable_next;
   logic pre_dis_reg, pre_dis_next;
   logic fault_en_reg, fault_en_next;
   logic fault_reg, fault_next;
   logic [15:0] div_reg, div_next;
   logic [31:0] ack_reg, ack_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [2:0] stat_reg, stat_next;
   logic [2:0] mask_reg, mask_next;
   logic pend_reg, pend_next;           // Frame request pending
   logic cmd_wr_reg, cmd_wr_next;       // Pending is a write
   logic [4:0] cmd_phy_reg, cmd_phy_next;
   logic [4:0] cmd_regad_reg, cmd_regad_next;
   logic [15:0] cmd_data_reg, cmd_data_next;
   // Bus address phase capture
   logic dp_wr_reg, dp_wr_next;
   logic dp_rd_next;
   logic [7:0] dp_addr_reg, dp_addr_next;
   logic [31:0] hrdata_next;
   // Frame engine state
   state_t st_reg, st_next;
   logic [5:0] bit_reg, bit_next;       // Bits left after the current one in this phase
   logic [31:0] sh_reg, sh_next;        // Outgoing frame word
   logic [15:0] in_reg, in_next;        // Incoming read data
   logic ack_ok_reg, ack_ok_next;       // Turnaround sampled low
   logic clk_reg, clk_next;             // Management clock level
   logic dout_reg, dout_next;
   logic doe_reg, doe_next;
   logic tick_rise, tick_fall;
   logic [31:0] control_word;
   logic mismatch;
   logic ev_done_p, ev_fault_p, ev_noack_p;

   mgmt_clk_div u_div (
      .hclk(hclk),
      .hresetn(hresetn),
      .divider(div_reg),
      .tick_rise(tick_rise),
      .tick_fall(tick_fall)
   );

   // Frame header: start 01, opcode, phy, reg, turnaround, data
   function automatic logic [31:0] frame_word(input logic wr, input logic [4:0] phy,
                                              input logic [4:0] ra, input logic [15:0] d);
      frame_word = {2'b01, wr ? 2'b01 : 2'b10, phy, ra, 2'b10, d};
   endfunction : frame_word

   // Control word with reserved bits zero
   always_comb begin
      control_word = 32'h0000_0000;
      control_word[mgmt_pkg::idle_bit] = (st_reg == st_idle);
      control_word[mgmt_pkg::enable_bit] = enable_reg;
      control_word[mgmt_pkg::chan_lsb +: 5] = mgmt_pkg::highest_channel;
      control_word[mgmt_pkg::pre_dis_bit] = pre_dis_reg;
      control_word[mgmt_pkg::fault_bit] = fault_reg;
      control_word[mgmt_pkg::fault_en_bit] = fault_en_reg;
      control_word[15:0] = div_reg;
   end

   // Data readback mismatch while driving, or clock readback mismatch even when idle, checked on the last high cycle, at the fall tick
   assign mismatch = fault_en_reg && tick_fall &&
                     ((doe_reg && (mgmt_data_i != dout_reg)) ||
                      (mgmt_clock_i != clk_reg));

   // Frame engine next state
   always_comb begin
      st_next = st_reg;
      bit_next = bit_reg;
      sh_next = sh_reg;
      in_next = in_reg;
      ack_ok_next = ack_ok_reg;
      clk_next = tick_rise | (clk_reg & ~tick_fall); // Level follows the divider ticks
      dout_next = dout_reg;
      doe_next = doe_reg;
      ev_done_p = 1'b0;
      ev_noack_p = 1'b0;
      ev_fault_p = mismatch;
      if (mismatch) begin
         st_next = st_idle;
         doe_next = 1'b0;
      end else begin
         case (st_reg)
            st_idle: begin
               doe_next = 1'b0;
               if (enable_reg && pend_reg && tick_fall) begin
                  sh_next = frame_word(cmd_wr_reg, cmd_phy_reg, cmd_regad_reg, cmd_data_reg);
                  doe_next = 1'b1;
                  ack_ok_next = 1'b1;
                  if (pre_dis_reg) begin
                     st_next = st_body;
                     bit_next = mgmt_pkg::body_bits - 6'h01;
                     dout_next = 1'b0;
                  end else begin
                     st_next = st_pre;
                     bit_next = mgmt_pkg::preamble_bits - 6'h01;
                     dout_next = 1'b1;
                  end
               end
            end
            st_pre: if (tick_fall) begin
               if (bit_reg == 6'h00) begin
                  st_next = st_body;
                  bit_next = mgmt_pkg::body_bits - 6'h01;
                  dout_next = sh_reg[31];
               end else begin
                  bit_next = bit_reg - 6'h01;
               end
            end
            st_body: begin
               // Reads release the line from turnaround onward
               if (tick_rise && !cmd_wr_reg && bit_reg <= 6'h11) begin
                  if (bit_reg == 6'h10) begin
                     ack_ok_next = ~mgmt_data_i;
                  end else if (bit_reg < 6'h10) begin
                     in_next = {in_reg[14:0], mgmt_data_i};
                  end
               end
               if (tick_fall) begin
                  if (bit_reg == 6'h00) begin
                     st_next = st_done;
                     doe_next = 1'b0;
                  end else begin
                     bit_next = bit_reg - 6'h01;
                     sh_next = {sh_reg[30:0], 1'b0};
                     dout_next = sh_reg[30];
                     if (!cmd_wr_reg && bit_reg == 6'h12) begin
                        doe_next = 1'b0;
                     end
                  end
               end
            end
            st_done: begin
               // Operation finished regardless of enable
               st_next = st_idle;
               ev_done_p = 1'b1;
               ev_noack_p = ~ack_ok_reg;
            end
            default: st_next = st_idle;
         endcase
      end
   end

   // Engine registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_reg <= st_idle;
         bit_reg <= 6'h00;
         sh_reg <= 32'h0000_0000;
         in_reg <= 16'h0000;
         ack_ok_reg <= 1'b0;
         clk_reg <= 1'b0;
         dout_reg <= 1'b0;
         doe_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         bit_reg <= bit_next;
         sh_reg <= sh_next;
         in_reg <= in_next;
         ack_ok_reg <= ack_ok_next;
         clk_reg <= clk_next;
         dout_reg <= dout_next;
         doe_reg <= doe_next;
      end
   end

   assign mgmt_clock = clk_reg;
   assign mgmt_data_o = dout_reg;
   assign mgmt_data_oe = doe_reg;

   // Bus slave and register next values; zero wait states
   always_comb begin
      dp_wr_next = hsel && hready && htrans[1] && hwrite;
      dp_rd_next = hsel && hready && htrans[1] && !hwrite;
      dp_addr_next = (hsel && hready && htrans[1]) ? haddr[7:0] : dp_addr_reg;
      enable_next = enable_reg;
      pre_dis_next = pre_dis_reg;
      fault_en_next = fault_en_reg;
      div_next = div_reg;
      mask_next = mask_reg;
      pend_next = pend_reg;
      cmd_wr_next = cmd_wr_reg;
      cmd_phy_next = cmd_phy_reg;
      cmd_regad_next = cmd_regad_reg;
      cmd_data_next = cmd_data_reg;
      fault_next = fault_reg;
      ack_next = ack_reg;
      stat_next = stat_reg;
      rdata_next = rdata_reg;
      hrdata_next = 32'h0000_0000;
      // Clears first so that hardware sets win in the same cycle
      if (dp_wr_reg) begin
         case (dp_addr_reg)
            mgmt_pkg::control_off: begin
               enable_next = hwdata[mgmt_pkg::enable_bit];
               pre_dis_next = hwdata[mgmt_pkg::pre_dis_bit];
               fault_en_next = hwdata[mgmt_pkg::fault_en_bit];
               div_next = hwdata[15:0];
               fault_next = fault_reg & ~hwdata[mgmt_pkg::fault_bit];
            end
            mgmt_pkg::ack_off: ack_next = ack_reg & ~hwdata;
            mgmt_pkg::cmd_off: if (hwdata[mgmt_pkg::go_bit] && !pend_reg) begin
               pend_next = 1'b1;
               cmd_wr_next = hwdata[mgmt_pkg::write_bit];
               cmd_regad_next = hwdata[mgmt_pkg::reg_lsb +: 5];
               cmd_phy_next = hwdata[mgmt_pkg::phy_lsb +: 5];
               cmd_data_next = hwdata[15:0];
            end
            mgmt_pkg::irq_stat_off: stat_next = stat_reg & ~hwdata[2:0];
            mgmt_pkg::irq_mask_off: mask_next = hwdata[2:0];
            default: ; // Unmapped or read-only: ignored
         endcase
      end
      if (ev_fault_p) begin
         fault_next = 1'b1;
         stat_next[mgmt_pkg::ev_fault] = 1'b1;
         pend_next = 1'b0;
      end
      if (ev_done_p) begin
         pend_next = 1'b0;
         ack_next[cmd_phy_reg] = ack_ok_reg;
         stat_next[mgmt_pkg::ev_done] = 1'b1;
         stat_next[mgmt_pkg::ev_noack] = stat_next[mgmt_pkg::ev_noack] | ev_noack_p;
         if (!cmd_wr_reg) begin
            rdata_next = {16'h0000, in_reg};
         end
      end
      if (dp_rd_next) begin
         case (haddr[7:0])
            mgmt_pkg::version_off: hrdata_next = {mgmt_pkg::module_type_code,
               mgmt_pkg::major_revision, mgmt_pkg::minor_revision};
            mgmt_pkg::control_off: hrdata_next = control_word;
            mgmt_pkg::ack_off: hrdata_next = ack_reg;
            mgmt_pkg::cmd_off: hrdata_next = {pend_reg, cmd_wr_reg, 4'h0, cmd_regad_reg,
                                              cmd_phy_reg, cmd_data_reg};
            mgmt_pkg::rdata_off: hrdata_next = rdata_reg;
            mgmt_pkg::irq_stat_off: hrdata_next = {29'h0, stat_reg};
            mgmt_pkg::irq_mask_off: hrdata_next = {29'h0, mask_reg};
            default: hrdata_next = 32'h0000_0000;
         endcase
      end
   end

   // Register file and bus flops
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         enable_reg <= 1'b0;
         pre_dis_reg <= 1'b0;
         fault_en_reg <= 1'b0;
         fault_reg <= 1'b0;
         div_reg <= mgmt_pkg::div_reset;
         ack_reg <= mgmt_pkg::ack_reset;
         rdata_reg <= 32'h0000_0000;
         stat_reg <= 3'h0;
         mask_reg <= 3'h0;
         pend_reg <= 1'b0;
         cmd_wr_reg <= 1'b0;
         cmd_phy_reg <= 5'h00;
         cmd_regad_reg <= 5'h00;
         cmd_data_reg <= 16'h0000;
         dp_wr_reg <= 1'b0;
         dp_addr_reg <= 8'h00;
         hrdata <= 32'h0000_0000;
      end else begin
         enable_reg <= enable_next;
         pre_dis_reg <= pre_dis_next;
         fault_en_reg <= fault_en_next;
         fault_reg <= fault_next;
         div_reg <= div_next;
         ack_reg <= ack_next;
         rdata_reg <= rdata_next;
         stat_reg <= stat_next;
         mask_reg <= mask_next;
         pend_reg <= pend_next;
         cmd_wr_reg <= cmd_wr_next;
         cmd_phy_reg <= cmd_phy_next;
         cmd_regad_reg <= cmd_regad_next;
         cmd_data_reg <= cmd_data_next;
         dp_wr_reg <= dp_wr_next;
         dp_addr_reg <= dp_addr_next;
         hrdata <= hrdata_next;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign irq = |(stat_reg & mask_reg);
endmodule : mgmt_ctrl
`default_nettype wire

// file: verif/mgmt_ctrl_sva.sv
/* Checker for the management master: register reads, reset state and data pin.
   Assumes it is bound to mgmt_ctrl and sees only that module's ports. */
`default_nettype none
module mgmt_ctrl_sva (
   input wire logic hclk,          // Bus clock
   input wire logic hresetn,       // Reset, active low
   input wire logic hsel,          // Select
   input wire logic [31:0] haddr,  // Address
   input wire logic [1:0] htrans,  // Transfer type
   input wire logic hwrite,        // Write flag
   input wire logic [31:0] hwdata, // Write data
   input wire logic hready,        // Bus ready
   input wire logic [31:0] hrdata, // Read data
   input wire logic mgmt_clock,    // Management clock
   input wire logic mgmt_data_o,   // Data level
   input wire logic mgmt_data_oe,  // Data enable
   input wire logic irq            // Interrupt
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic take;            // Transfer accepted
   logic rd_ctl;          // Control read accepted
   logic wr_ctl;          // Control write accepted
   logic [31:0] ver_word; // Expected version word
   assign take = hsel && hready && htrans[1];
   assign rd_ctl = take && !hwrite && haddr[7:0] == mgmt_pkg::control_off;
   assign wr_ctl = take && hwrite && haddr[7:0] == mgmt_pkg::control_off;
   assign ver_word = {mgmt_pkg::module_type_code, mgmt_pkg::major_revision,
      mgmt_pkg::minor_revision};
   // Quiet outputs right after reset
   AST_RESET: assert property ($rose(hresetn) |->
      !mgmt_data_oe && !mgmt_clock && !irq && hrdata == 32'h0) else $error("not quiet");
   AST_VERSION: assert property (
      take && !hwrite && haddr[7:0] == mgmt_pkg::version_off |=> hrdata == ver_word)
      else $error("version word wrong");
   AST_CHANNEL: assert property (
      rd_ctl |=> hrdata[28:24] == mgmt_pkg::highest_channel) else $error("channel field");
   AST_RESERVED: assert property (
      rd_ctl |=> !hrdata[29] && hrdata[23:21] == 3'h0 && hrdata[17:16] == 2'h0)
      else $error("reserved bits set");
   // Driving the pin means a frame is in progress
   AST_BUSY: assert property (rd_ctl && mgmt_data_oe |=> !hrdata[31])
      else $error("idle while driving");
   // Data moves only while the clock is low
   AST_DATA_EDGE: assert property (
      mgmt_data_oe && $changed(mgmt_data_o) |-> !mgmt_clock) else $error("data on high");
   AST_ACK_CLEAR: assert property (
      take && hwrite && haddr[7:0] == mgmt_pkg::ack_off ##1 hwdata == 32'hffff_ffff
      ##1 take && !hwrite && haddr[7:0] == mgmt_pkg::ack_off |=> hrdata == 32'h0)
      else $error("ack flags not cleared");
   AST_FAULT_CLEAR: assert property (
      wr_ctl ##1 hwdata[19] && !hwdata[18] ##1 rd_ctl |=> !hrdata[19])
      else $error("fault not cleared");
   // Zero divider freezes the clock
   AST_CLK_STOP: assert property (
      wr_ctl ##1 hwdata[15:0] == 16'h0 |=> ##1 $stable(mgmt_clock) [*8])
      else $error("clock runs at zero");
   COV_VERSION: cover property (take && haddr[7:0] == mgmt_pkg::version_off);
   COV_FRAME: cover property ($rose(mgmt_data_oe));
   COV_IRQ: cover property ($rose(irq));
endmodule : mgmt_ctrl_sva
bind mgmt_ctrl mgmt_ctrl_sva i_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
   .hrdata(hrdata), .mgmt_clock(mgmt_clock), .mgmt_data_o(mgmt_data_o),
   .mgmt_data_oe(mgmt_data_oe), .irq(irq));
`default_nettype wire

// file: verif/phy_model.sv
/* Far-end device on the management data line: answers reads to one address.
   Assumes an open-drain line with a pull-up resolved by the bench. */
`default_nettype none
module phy_model #(
   parameter logic [4:0] ack_phy = 5'h05,     // Address this device answers
   parameter logic [15:0] rd_data = 16'hc3a5  // Register value returned
) (
   input wire logic mgmt_clock, // Management clock
   input wire logic line,       // Resolved line level
   output logic drive_low       // Pulls the line low
);
   logic [5:0] cnt = 6'h0;  // Frame bits sampled, zero when idle
   logic [12:0] hdr = 13'h0; // Start tail, opcode, addresses
   logic [4:0] k = 5'h0;    // Falling edges into the answer
   initial drive_low = 1'b0;
   // Sample on rising edges; 31 bits after the start's first zero
   always @(posedge mgmt_clock) begin
      if (cnt == 6'h0) begin
         if (!line) cnt <= 6'h1;
      end else begin
         hdr <= {hdr[11:0], line};
         cnt <= (cnt == 6'd31) ? 6'h0 : cnt + 6'h1;
      end
   end
   // Answer after falling edges: turnaround, then data, most significant first
   always @(negedge mgmt_clock) begin
      if (k == 5'h0) begin
         if (cnt == 6'd14 && hdr[12:5] == {3'b110, ack_phy}) k <= 5'h1;
      end else begin
         k <= (k == 5'd18) ? 5'h0 : k + 5'h1;
      end
      // Other addresses get no answer: line left to the pull-up
      drive_low <= (k == 5'h1) || (k >= 5'h2 && k <= 5'd17 && !rd_data[5'd17 - k]);
   end
endmodule : phy_model
`default_nettype wire

// file: verif/tb_mdio_master_control_status.sv
/* Bench for mgmt_ctrl: AHB-Lite register tasks and frame scenarios.
   Assumes phy_model on a pulled-up data line and the bound checker. */
`default_nettype none
module tb_mdio_master_control_status;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [4:0] phy_a = 5'h05;     // Address the model answers
   localparam logic [15:0] phy_d = 16'hc3a5; // Data the model returns
   localparam logic [7:0] ctl = mgmt_pkg::control_off;
   localparam logic [7:0] ist = mgmt_pkg::irq_stat_off;
   localparam logic [7:0] ackr = mgmt_pkg::ack_off;
   localparam logic [7:0] cmdr = mgmt_pkg::cmd_off;
   logic hclk = 1'b0;           // Bus clock
   logic hresetn = 1'b0;        // Reset, active low
   logic hsel = 1'b0;           // Select
   logic [31:0] haddr = 32'h0;  // Address
   logic [1:0] htrans = 2'h0;   // Transfer type
   logic hwrite = 1'b0;         // Write flag
   logic [31:0] hwdata = 32'h0; // Write data
   logic [31:0] hrdata;         // Read data
   logic hready;                // Slave ready
   logic mgmt_clock;            // Management clock
   logic mgmt_data_o;           // Data level
   logic mgmt_data_oe;          // Data enable
   logic irq;                   // Interrupt
   logic phy_low;               // Model pulls low
   logic flip = 1'b0;           // Breaks clock readback
   logic line;                  // Resolved data line
   logic [31:0] q;              // Last read word
   int cyc = 0;                 // Cycle count
   int ones = 0;                // Driven ones seen on rising edges
   int edges = 0;               // Clock transitions
   int e;                       // Snapshot of edges
   time t0;                     // Rising edge time
   int mismatches = 0;
   int n_compared = 0;
   always #5 hclk = ~hclk;
   // Open drain with pull-up: low if anyone pulls low
   assign line = !((mgmt_data_oe && !mgmt_data_o) || phy_low);
   mgmt_ctrl i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hready), .hresp(), .mgmt_clock(mgmt_clock),
      .mgmt_data_o(mgmt_data_o), .mgmt_data_oe(mgmt_data_oe), .mgmt_data_i(line),
      .mgmt_clock_i(mgmt_clock ^ flip), .irq(irq));
   phy_model #(.ack_phy(phy_a), .rd_data(phy_d)) i_phy (.mgmt_clock(mgmt_clock),
      .line(line), .drive_low(phy_low));
   always @(posedge mgmt_clock) if (mgmt_data_oe && mgmt_data_o) ones++;
   always @(mgmt_clock) edges++;
   // Hang cut-off, well above the few thousand cycles needed
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         mismatches++;
         test_done();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Single transfer; request held until ready is sampled high
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      q = hrdata;
   endtask : bus
   function automatic logic [31:0] cmd(input logic w, input logic [4:0] p,
      input logic [4:0] r);
      return {1'b1, w, 4'h0, r, p, 16'h0};
   endfunction : cmd
   // Poll an event bit, see the interrupt, clear the bit
   task automatic wait_ev(input int b);
      q = 32'h0;
      while (q[b] !== 1'b1) bus(1'b0, ist, 32'h0);
      chk({31'h0, irq}, 32'h1);
      bus(1'b1, ist, 32'h1 << b);
   endtask : wait_ev
   task automatic wait_oe;
      while (mgmt_data_oe !== 1'b1) @(posedge hclk);
   endtask : wait_oe
   task automatic test_done;
      $display("Compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : test_done
   initial begin
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      bus(1'b0, ctl, 32'h0);
      chk(q, 32'h8100_00ff);
      bus(1'b0, mgmt_pkg::version_off, 32'h0);
      chk(q, {mgmt_pkg::module_type_code, 16'h0100});
      bus(1'b0, ackr, 32'h0);
      chk(q, 32'h0);
      bus(1'b1, ctl, 32'hbfe3_0003);
      bus(1'b0, ctl, 32'h0);
      chk(q, 32'h8100_0003);
      $display("Test done: reset values");
      // Read with preamble, divider three
      bus(1'b1, mgmt_pkg::irq_mask_off, 32'h7);
      bus(1'b1, ctl, 32'h4000_0003);
      ones = 0;
      bus(1'b1, cmdr, cmd(1'b0, phy_a, 5'h02));
      wait_oe();
      bus(1'b0, ctl, 32'h0);
      chk(q & 32'h8000_0000, 32'h0);
      @(posedge mgmt_clock);
      t0 = $time;
      @(posedge mgmt_clock);
      chk(32'(($time - t0) / 10), 32'h4);
      wait_ev(mgmt_pkg::ev_done);
      @(posedge hclk);
      chk({31'h0, irq}, 32'h0);
      bus(1'b0, mgmt_pkg::rdata_off, 32'h0);
      chk(q & 32'hffff, {16'h0, phy_d});
      chk(32'(ones), 32'(34 + $countones(phy_a) + $countones(5'h02)));
      bus(1'b0, ackr, 32'h0);
      chk(q, 32'h1 << phy_a);
      bus(1'b0, ctl, 32'h0);
      chk(q, 32'hc100_0003);
      $display("Test done: read frame");
      // No preamble; unanswered address
      bus(1'b1, ctl, 32'h4010_0003);
      ones = 0;
      bus(1'b1, cmdr, cmd(1'b1, 5'h09, 5'h01));
      wait_ev(mgmt_pkg::ev_done);
      chk(32'(ones), 32'h6);
      bus(1'b0, ackr, 32'h0);
      chk(q, 32'h0000_0220);
      bus(1'b1, cmdr, cmd(1'b0, 5'h09, 5'h01));
      wait_ev(mgmt_pkg::ev_done);
      bus(1'b0, ist, 32'h0);
      chk(q & 32'h4, 32'h4);
      bus(1'b1, ist, 32'h7);
      bus(1'b0, ackr, 32'h0);
      chk(q, 32'h1 << phy_a);
      bus(1'b1, ackr, 32'hffff_ffff);
      bus(1'b0, ackr, 32'h0);
      chk(q, 32'h0);
      $display("Test done: preamble off and acknowledge");
      // Disable in mid-frame, then hold off a request
      bus(1'b1, ctl, 32'h4000_0003);
      bus(1'b1, cmdr, cmd(1'b0, phy_a, 5'h03));
      wait_oe();
      bus(1'b1, ctl, 32'h0000_0003);
      bus(1'b0, ctl, 32'h0);
      chk(q & 32'h8000_0000, 32'h0);
      wait_ev(mgmt_pkg::ev_done);
      bus(1'b0, ctl, 32'h0);
      chk(q, 32'h8100_0003);
      bus(1'b1, cmdr, cmd(1'b0, phy_a, 5'h03));
      repeat (100) @(posedge hclk);
      bus(1'b0, ctl, 32'h0);
      chk(q, 32'h8100_0003);
      bus(1'b1, ctl, 32'h0);
      repeat (4) @(posedge hclk);
      e = edges;
      repeat (60) @(posedge hclk);
      chk(32'(edges - e), 32'h0);
      bus(1'b1, ctl, 32'h4000_0003);
      wait_ev(mgmt_pkg::ev_done);
      $display("Test done: disable and zero divider");
      // Broken clock readback, detection off then on
      flip <= 1'b1;
      bus(1'b1, cmdr, cmd(1'b1, phy_a, 5'h04));
      wait_ev(mgmt_pkg::ev_done);
      bus(1'b1, ctl, 32'h4004_0003);
      bus(1'b1, cmdr, cmd(1'b1, phy_a, 5'h04));
      wait_ev(mgmt_pkg::ev_fault);
      repeat (10) @(posedge hclk);
      bus(1'b1, ctl, 32'h4004_0003);
      bus(1'b0, ctl, 32'h0);
      chk(q, 32'hc10c_0003);
      flip <= 1'b0;
      bus(1'b1, ctl, 32'h4008_0003);
      bus(1'b0, ctl, 32'h0);
      chk(q, 32'hc100_0003);
      $display("Test done: pin fault");
      test_done();
   end
endmodule : tb_mdio_master_control_status
`default_nettype wire
